// ===== rtl/keypad_irq_config_pullup.sv
`timescale 1ns/1ps
module keypad_irq_config_pullup
    import keypad_irq_pkg::*;
#(
    parameter int RELEASE_COUNT = RELEASE_CYCLES,
    parameter int DEPTH         = FIFO_DEPTH
)(
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic                  ptrLoad,
    input  wire logic [7:0]            ptrData,
    input  wire logic                  wrStrobe,
    input  wire logic [7:0]            wrData,
    input  wire logic                  rdStrobe,
    output logic      [7:0]            rdData,
    input  wire logic                  keyEvent,
    input  wire logic [7:0]            keyCode,
    input  wire logic                  saluteDetect,
    input  wire logic                  lockStart,
    input  wire logic                  keypadLocked,
    input  wire logic [INPUT_PINS-1:0] inputChange,
    input  wire logic [INPUT_PINS-1:0] inputIrqEnable,
    output logic      [7:0]            pullupOffRows,
    output logic      [7:0]            pullupOffColsLow,
    output logic      [1:0]            pullupOffColsHigh,
    output logic                       irqOut_n
);
    typedef enum logic [1:0] {
        IRQ_IDLE    = 2'b00,
        IRQ_ACTIVE  = 2'b01,
        IRQ_RELEASE = 2'b11
    } irq_state_t;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int IW = $clog2(DEPTH);
    localparam int RW = $clog2(RELEASE_COUNT + 1);
    logic [7:0]    ptr_reg;
    logic [7:0]    config_reg;
    logic [7:0]    flags_reg;
    logic [7:0]    flags_next;
    logic [7:0]    fifoMem [DEPTH];
    logic [IW-1:0] head_reg;
    logic [IW-1:0] tail_reg;
    logic [CW-1:0] count_reg;
    logic [2:0]    held_reg;
    logic [RW-1:0] relCnt_reg;
    irq_state_t    irqState_reg;
    logic          fifoFull;
    logic          popReq;
    logic          pushDrop;
    logic          pushShift;
    logic          spillEvt;
    logic          saluteEvt;
    logic          inputEvt;
    logic          flagWrite;
    logic          clearTry;
    logic          irqPending;

    // Advance a queue index with wrap at the depth
    function automatic logic [IW-1:0] stepIdx(input logic [IW-1:0] idx);
        stepIdx = (idx == IW'(DEPTH - 1)) ? '0 : idx + IW'(1);
    endfunction
    // Match a key code against one of the watched codes
    function automatic logic isKey(input logic [7:0] code,
                                   input logic [6:0] key);
        isKey = (code[6:0] == key);
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // Event decode
    assign fifoFull  = (count_reg == CW'(DEPTH));
    assign popReq    = rdStrobe && (ptr_reg == ADDR_EVT_POP)
                       && (count_reg != '0);
    assign pushDrop  = keyEvent && fifoFull && !popReq
                       && !config_reg[CFG_SPILL_POL];
    assign pushShift = keyEvent && fifoFull && !popReq
                       && config_reg[CFG_SPILL_POL];
    // Both bits must be set; the enable alone never raises spill
    assign spillEvt  = pushShift && config_reg[CFG_SPILL_IRQ];
    // Watched keys held together, the false pairs included on purpose
    assign saluteEvt = saluteDetect
                       || (held_reg[0] && (held_reg[1] || held_reg[2]));
    assign inputEvt  = |(inputChange & inputIrqEnable)
                       && !(keypadLocked
                            && config_reg[CFG_LOCK_TRACK]);
    assign flagWrite = wrStrobe && (ptr_reg == ADDR_FLAGS);
    assign clearTry  = flagWrite && (wrData[FLG_KEY] || wrData[FLG_INPUT])
                       && ((count_reg != '0) || inputEvt);
    ////////////////////////////////////////////////////////////////////////
    // Register pointer, stepping only when auto-step is on
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            ptr_reg <= READ_ZERO;
        else if (ptrLoad)
            ptr_reg <= ptrData;
        else if ((wrStrobe || rdStrobe) && config_reg[CFG_AUTOSTEP])
            ptr_reg <= ptr_reg + 8'h01;
    end
    // Writable configuration and pull-up registers
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            config_reg        <= CONFIG_RESET;
            pullupOffRows     <= PULL_RESET;
            pullupOffColsLow  <= PULL_RESET;
            pullupOffColsHigh <= PULL_RESET[1:0];
        end
        else if (wrStrobe)
        begin
            case (ptr_reg)
                ADDR_CONFIG:     config_reg <= wrData;
                ADDR_PULL_ROWS:  pullupOffRows <= wrData;
                ADDR_PULL_COLLO: pullupOffColsLow <= wrData;
                ADDR_PULL_COLHI: pullupOffColsHigh <= wrData[1:0];
                default:         config_reg <= config_reg;
            endcase
        end
    end

    // Read data, popping the queue head on an event read
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            rdData <= READ_ZERO;
        else if (rdStrobe)
        begin
            case (ptr_reg)
                ADDR_CONFIG:     rdData <= config_reg;
                ADDR_FLAGS: rdData <= flags_reg & FLAGS_USED_MASK;
                ADDR_EVT_COUNT:  rdData <= 8'(count_reg);
                ADDR_EVT_POP:    rdData <= popReq ? fifoMem[head_reg]
                                                  : READ_ZERO;
                ADDR_PULL_ROWS:  rdData <= pullupOffRows;
                ADDR_PULL_COLLO: rdData <= pullupOffColsLow;
                ADDR_PULL_COLHI: rdData <= {6'h00, pullupOffColsHigh};
                default:         rdData <= READ_ZERO;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Event queue storage
    always_ff @(posedge clock)
    begin
        if (keyEvent && !pushDrop)
            fifoMem[tail_reg] <= keyCode;
    end

    // Queue pointers and fill count
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            head_reg  <= '0;
            tail_reg  <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (keyEvent && !pushDrop)
                tail_reg <= stepIdx(tail_reg);
            if (popReq || pushShift)
                head_reg <= stepIdx(head_reg);
            if (keyEvent && !pushDrop && !pushShift && !popReq)
                count_reg <= count_reg + CW'(1);
            else if (popReq && !keyEvent)
                count_reg <= count_reg - CW'(1);
        end
    end

    // Track which watched keys are held down
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            held_reg <= 3'h0;
        else if (keyEvent)
        begin
            if (isKey(keyCode, KEY_CODE_A))
                held_reg[0] <= keyCode[KEY_PRESS_BIT];
            if (isKey(keyCode, KEY_CODE_B))
                held_reg[1] <= keyCode[KEY_PRESS_BIT];
            if (isKey(keyCode, KEY_CODE_C))
                held_reg[2] <= keyCode[KEY_PRESS_BIT];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Event flags: write one clears, a new event or a non-empty queue in the same cycle wins
    always_comb
    begin
        flags_next = flags_reg;
        if (flagWrite)
            flags_next = flags_reg & ~wrData;
        if ((keyEvent && !pushDrop) || (count_reg != '0))
            flags_next[FLG_KEY] = 1'b1;
        if (inputEvt)
            flags_next[FLG_INPUT] = 1'b1;
        if (lockStart)
            flags_next[FLG_LOCK] = 1'b1;
        if (spillEvt)
            flags_next[FLG_SPILL] = 1'b1;
        if (saluteEvt)
            flags_next[FLG_SALUTE] = 1'b1;
        flags_next = flags_next & FLAGS_USED_MASK;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            flags_reg <= FLAGS_RESET;
        else
            flags_reg <= flags_next;
    end
    ////////////////////////////////////////////////////////////////////////
    // Interrupt output, with optional release pulse on a futile clear
    assign irqPending =
        (flags_next[FLG_KEY] && config_reg[CFG_KEY_IRQ_ON])
        || flags_next[FLG_INPUT]
        || (flags_next[FLG_LOCK] && config_reg[CFG_LOCK_IRQ_ON])
        || flags_next[FLG_SPILL]
        || flags_next[FLG_SALUTE];

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irqState_reg <= IRQ_IDLE;
            relCnt_reg   <= '0;
            irqOut_n     <= 1'b1;
        end
        else
        begin
            case (irqState_reg)
                IRQ_IDLE:
                begin
                    irqOut_n <= !irqPending;
                    if (irqPending)
                        irqState_reg <= IRQ_ACTIVE;
                end
                IRQ_ACTIVE:
                begin
                    if (clearTry && irqPending
                        && config_reg[CFG_PULSE_MODE])
                    begin
                        irqState_reg <= IRQ_RELEASE;
                        relCnt_reg   <= RW'(RELEASE_COUNT - 1);
                        irqOut_n     <= 1'b1;
                    end
                    else
                    begin
                        irqOut_n <= !irqPending;
                        if (!irqPending)
                            irqState_reg <= IRQ_IDLE;
                    end
                end
                IRQ_RELEASE:
                begin
                    if (relCnt_reg == '0)
                    begin
                        irqOut_n     <= !irqPending;
                        irqState_reg <= irqPending ? IRQ_ACTIVE : IRQ_IDLE;
                    end
                    else
                        relCnt_reg <= relCnt_reg - RW'(1);
                end
                default:
                begin
                    irqState_reg <= IRQ_IDLE;
                    irqOut_n     <= 1'b1;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_HIGH_BITS_ZERO: assert property (flags_reg[7:5] == 3'h0)
        else $error("unused flag bits set");
    AST_ZERO_WRITE_KEEPS: assert property (
        flagWrite && wrData == 8'h00
        |=> ($past(flags_reg) & ~flags_reg) == 8'h00)
        else $error("zero write cleared a flag");
    AST_SALUTE_STICKY: assert property (
        flags_reg[FLG_SALUTE] && !(flagWrite && wrData[FLG_SALUTE])
        |=> flags_reg[FLG_SALUTE])
        else $error("salute flag dropped without clear");
    AST_FALSE_PAIR: assert property (
        held_reg[0] && held_reg[1] |=> flags_reg[FLG_SALUTE])
        else $error("key pair did not set salute flag");
    AST_SPILL_NEEDS_BOTH: assert property (
        !flags_reg[FLG_SPILL] && !(config_reg[CFG_SPILL_IRQ]
        && config_reg[CFG_SPILL_POL]) |=> !flags_reg[FLG_SPILL])
        else $error("spill flag without both enables");
    AST_SPILL_ON_LOSS: assert property (
        pushShift && config_reg[CFG_SPILL_IRQ] |=> flags_reg[FLG_SPILL])
        else $error("spill flag missed");
    AST_FIFO_BOUND: assert property (count_reg <= CW'(DEPTH))
        else $error("queue count over depth");
    AST_DROP_KEEPS_FULL: assert property (
        pushDrop |=> count_reg == CW'(DEPTH) && tail_reg == $past(tail_reg))
        else $error("dropped event changed queue");
    AST_LOCK_FLAG: assert property (
        lockStart |=> flags_reg[FLG_LOCK])
        else $error("lock start not flagged");
    AST_LOCK_TRACK: assert property (
        keypadLocked && config_reg[CFG_LOCK_TRACK] && !flags_reg[FLG_INPUT]
        |=> !flags_reg[FLG_INPUT])
        else $error("input tracked while locked");
    AST_AUTOSTEP: assert property (
        rdStrobe && !ptrLoad && !config_reg[CFG_AUTOSTEP]
        |=> $stable(ptr_reg))
        else $error("pointer stepped with auto-step off");
    AST_RELEASE_HIGH: assert property (
        $rose(irqState_reg == IRQ_RELEASE) |-> irqOut_n [*8])
        else $error("interrupt not released");
    AST_IRQ_FOLLOWS: assert property (
        irqState_reg == IRQ_IDLE |=> irqOut_n == !$past(irqPending))
        else $error("interrupt level wrong");
endmodule

// ===== rtl/keypad_irq_pkg.sv
package keypad_irq_pkg;
    // Register pointer values
    localparam logic [7:0] ADDR_CONFIG     = 8'h01;
    localparam logic [7:0] ADDR_FLAGS      = 8'h02;
    localparam logic [7:0] ADDR_EVT_COUNT  = 8'h03;
    localparam logic [7:0] ADDR_EVT_POP    = 8'h04;
    localparam logic [7:0] ADDR_PULL_ROWS  = 8'h2C;
    localparam logic [7:0] ADDR_PULL_COLHI = 8'h2E;
    localparam logic [7:0] ADDR_PULL_COLLO = 8'h3D;

    // Configuration bit positions
    localparam int CFG_KEY_IRQ_ON  = 0;
    localparam int CFG_LOCK_IRQ_ON = 2;
    localparam int CFG_SPILL_IRQ   = 3;
    localparam int CFG_PULSE_MODE  = 4;
    localparam int CFG_SPILL_POL   = 5;
    localparam int CFG_LOCK_TRACK  = 6;
    localparam int CFG_AUTOSTEP    = 7;

    // Event flag bit positions
    localparam int FLG_KEY    = 0;
    localparam int FLG_INPUT  = 1;
    localparam int FLG_LOCK   = 2;
    localparam int FLG_SPILL  = 3;
    localparam int FLG_SALUTE = 4;
    localparam logic [7:0] FLAGS_USED_MASK = 8'h1F;

    // Reset values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET  = 8'h00;
    localparam logic [7:0] PULL_RESET   = 8'h00;
    localparam logic [7:0] READ_ZERO    = 8'h00;

    // Key codes that light the salute flag, including the known false ones
    localparam logic [6:0] KEY_CODE_A = 7'h01;
    localparam logic [6:0] KEY_CODE_B = 7'h0B;
    localparam logic [6:0] KEY_CODE_C = 7'h15;
    localparam int KEY_PRESS_BIT = 7;

    // Event queue and timing
    localparam int FIFO_DEPTH   = 10;
    localparam int CLOCK_MHZ    = 200;
    localparam int RELEASE_US   = 50;
    localparam int RELEASE_CYCLES = RELEASE_US * CLOCK_MHZ;
    localparam int INPUT_PINS   = 18;
endpackage

// ===== test/host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
// Host side of the byte register port; requests change at falling edges
module host_model
    import keypad_irq_pkg::*;
(
    input  wire logic       clock,
    output logic            ptrLoad,
    output logic      [7:0] ptrData,
    output logic            wrStrobe,
    output logic      [7:0] wrData,
    output logic            rdStrobe,
    input  wire logic [7:0] rdData
);
    // Idle levels at time zero
    initial
    begin
        ptrLoad  = 1'b0;
        ptrData  = 8'h00;
        wrStrobe = 1'b0;
        wrData   = 8'h00;
        rdStrobe = 1'b0;
    end
    // Pointer load for one edge; data then inverted so stale bytes never match
    task automatic setp(input logic [7:0] a);
        @(negedge clock);
        ptrLoad = 1'b1;
        ptrData = a;
        @(negedge clock);
        ptrLoad = 1'b0;
        ptrData = ~a;
    endtask
    // One byte written at the current pointer
    task automatic wr1(input logic [7:0] d);
        @(negedge clock);
        wrStrobe = 1'b1;
        wrData   = d;
        @(negedge clock);
        wrStrobe = 1'b0;
        wrData   = ~d;
    endtask
    // One byte read; taken a full cycle after the strobe edge
    task automatic rd1(output logic [7:0] d);
        @(negedge clock);
        rdStrobe = 1'b1;
        @(negedge clock);
        rdStrobe = 1'b0;
        @(negedge clock);
        d = rdData;
    endtask
    // Empties queue entries at once instead of waiting on a spill
    task automatic drain(input int n);
        logic [7:0] d;
        setp(ADDR_EVT_POP);
        repeat (n) rd1(d);
    endtask
endmodule

// ===== test/tb_keypad_irq_config_pullup.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////
module tb_keypad_irq_config_pullup;
    import keypad_irq_pkg::*;
    localparam int REL = 20;
    logic                  clock;
    logic                  sysRst;
    logic                  ptrLoad, wrStrobe, rdStrobe;
    logic [7:0]            ptrData, wrData, rdData, keyCode;
    logic                  keyEvent, saluteDetect, lockStart, keypadLocked;
    logic [7:0]            pullupOffRows, pullupOffColsLow;
    logic [1:0]            pullupOffColsHigh;
    logic                  irqOut_n;
    logic [INPUT_PINS-1:0] inputChange, inputIrqEnable;
    int                    errorCnt = 0;
    int                    nChecks = 0;
    // Block under test, short release window
    keypad_irq_config_pullup #(.RELEASE_COUNT(REL))
        keypad_irq_config_pullup_inst
    (
        .clock(clock), .sys_rst(sysRst), .ptrLoad(ptrLoad), .ptrData(ptrData),
        .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
        .rdData(rdData), .keyEvent(keyEvent), .keyCode(keyCode),
        .saluteDetect(saluteDetect), .lockStart(lockStart),
        .keypadLocked(keypadLocked), .inputChange(inputChange),
        .inputIrqEnable(inputIrqEnable), .pullupOffRows(pullupOffRows),
        .pullupOffColsLow(pullupOffColsLow),
        .pullupOffColsHigh(pullupOffColsHigh), .irqOut_n(irqOut_n)
    );
    // Host partner on the register port
    host_model host_model_inst
    (
        .clock(clock), .ptrLoad(ptrLoad), .ptrData(ptrData),
        .wrStrobe(wrStrobe), .wrData(wrData), .rdStrobe(rdStrobe),
        .rdData(rdData)
    );
    // 200 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    // Comparison, access and stimulus helpers
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        nChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model_inst.setp(a);
        host_model_inst.wr1(d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        host_model_inst.setp(a);
        host_model_inst.rd1(d);
    endtask
    task automatic rf(input logic [7:0] e);
        logic [7:0] d;
        rd(ADDR_FLAGS, d);
        chk8(d, e);
    endtask
    task automatic push(input logic [7:0] c);
        @(negedge clock);
        keyEvent = 1'b1;
        keyCode  = c;
        @(negedge clock);
        keyEvent = 1'b0;
        keyCode  = ~c;
    endtask
    task automatic pulse_in(input int n);
        @(negedge clock);
        inputChange = 18'h00001 << n;
        @(negedge clock);
        inputChange = 18'h00000;
    endtask
    task automatic pulse_lock();
        @(negedge clock);
        lockStart = 1'b1;
        @(negedge clock);
        lockStart = 1'b0;
    endtask
    // Lock level and per-pin input enables, changed at a falling edge
    task automatic set_levels(input logic lk,
                              input logic [INPUT_PINS-1:0] en);
        @(negedge clock);
        keypadLocked   = lk;
        inputIrqEnable = en;
    endtask
    task automatic combo(input logic [6:0] a, b, c);
        push({1'b1, a});
        push({1'b1, b});
        if (c != 7'h00) push({1'b1, c});
        rf(8'h11);
        push({1'b0, a});
        push({1'b0, b});
        if (c != 7'h00) push({1'b0, c});
        host_model_inst.drain(c != 7'h00 ? 6 : 4);
        wr(ADDR_FLAGS, 8'h1F);
        rf(8'h00);
    endtask
    task automatic spill(input logic [7:0] cfg, fl, head, last,
                         input logic irq);
        logic [7:0] d;
        wr(ADDR_CONFIG, cfg);
        for (int i = 0; i < 11; i++) push(8'h20 + 8'(i));
        rf(fl);
        chk1(irqOut_n, irq);
        rd(ADDR_EVT_COUNT, d);
        chk8(d, 8'h0A);
        rd(ADDR_EVT_POP, d);
        chk8(d, head);
        host_model_inst.drain(8);
        rd(ADDR_EVT_POP, d);
        chk8(d, last);
        wr(ADDR_FLAGS, 8'h1F);
        rf(8'h00);
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Scenarios in sequence after a 20-cycle reset
    initial
    begin
        logic [7:0] d;
        sysRst = 1'b1;
        keyEvent = 1'b0;
        keyCode = 8'h00;
        saluteDetect = 1'b0;
        lockStart = 1'b0;
        keypadLocked = 1'b0;
        inputChange = 18'h00000;
        inputIrqEnable = 18'h00000;
        repeat (20) @(negedge clock);
        sysRst = 1'b0;
        rd(ADDR_CONFIG, d);
        chk8(d, 8'h00);
        rf(8'h00);
        chk8(pullupOffRows | pullupOffColsLow, 8'h00);
        chk8({6'h00, pullupOffColsHigh}, 8'h00);
        chk1(irqOut_n, 1'b1);
        $display("reset test done");
        wr(ADDR_PULL_ROWS, 8'hA5);
        wr(ADDR_PULL_COLLO, 8'h5A);
        wr(ADDR_PULL_COLHI, 8'hFE);
        chk8(pullupOffRows, 8'hA5);
        chk8(pullupOffColsLow, 8'h5A);
        chk8({6'h00, pullupOffColsHigh}, 8'h02);
        rd(ADDR_PULL_ROWS, d);
        chk8(d, 8'hA5);
        rd(8'h50, d);
        chk8(d, 8'h00);
        $display("pull-up test done");
        wr(ADDR_CONFIG, 8'h80);
        host_model_inst.setp(ADDR_PULL_ROWS);
        host_model_inst.wr1(8'h11);
        host_model_inst.wr1(8'h22);
        chk8(pullupOffRows, 8'h11);
        host_model_inst.setp(ADDR_CONFIG);
        host_model_inst.rd1(d);
        host_model_inst.rd1(d);
        chk8(d, 8'h00);
        wr(ADDR_CONFIG, 8'h00);
        host_model_inst.wr1(8'h33);
        host_model_inst.setp(ADDR_PULL_ROWS);
        host_model_inst.wr1(8'h44);
        host_model_inst.wr1(8'h00);
        chk8(pullupOffRows, 8'h00);
        $display("autostep test done");
        wr(ADDR_CONFIG, 8'h01);
        push(8'h85);
        chk1(irqOut_n, 1'b0);
        wr(ADDR_FLAGS, 8'h00);
        rf(8'h01);
        rd(ADDR_EVT_POP, d);
        chk8(d, 8'h85);
        wr(ADDR_FLAGS, 8'h01);
        rf(8'h00);
        chk1(irqOut_n, 1'b1);
        $display("key event test done");
        wr(ADDR_CONFIG, 8'h00);
        pulse_lock();
        rf(8'h04);
        chk1(irqOut_n, 1'b1);
        wr(ADDR_FLAGS, 8'h04);
        wr(ADDR_CONFIG, 8'h04);
        pulse_lock();
        chk1(irqOut_n, 1'b0);
        wr(ADDR_FLAGS, 8'hE0);
        rf(8'h04);
        wr(ADDR_FLAGS, 8'h04);
        chk1(irqOut_n, 1'b1);
        $display("lock test done");
        wr(ADDR_CONFIG, 8'h00);
        @(negedge clock);
        saluteDetect = 1'b1;
        @(negedge clock);
        saluteDetect = 1'b0;
        wr(ADDR_FLAGS, 8'hEF);
        rf(8'h10);
        wr(ADDR_FLAGS, 8'h10);
        combo(7'h01, 7'h0B, 7'h00);
        combo(7'h01, 7'h15, 7'h00);
        combo(7'h15, 7'h01, 7'h0B);
        $display("salute test done");
        set_levels(1'b0, 18'h20020);
        pulse_in(6);
        rf(8'h00);
        pulse_in(17);
        rf(8'h02);
        wr(ADDR_FLAGS, 8'h02);
        pulse_in(5);
        rf(8'h02);
        wr(ADDR_FLAGS, 8'h02);
        wr(ADDR_CONFIG, 8'h40);
        set_levels(1'b1, 18'h20020);
        pulse_in(5);
        rf(8'h00);
        wr(ADDR_CONFIG, 8'h00);
        pulse_in(5);
        rf(8'h02);
        wr(ADDR_FLAGS, 8'h02);
        set_levels(1'b0, 18'h20020);
        $display("input test done");
        spill(8'h08, 8'h01, 8'h20, 8'h29, 1'b1);
        spill(8'h28, 8'h09, 8'h21, 8'h2A, 1'b0);
        $display("spill test done");
        wr(ADDR_CONFIG, 8'h11);
        push(8'h02);
        wr(ADDR_FLAGS, 8'h01);
        repeat (4) @(negedge clock);
        chk1(irqOut_n, 1'b1);
        repeat (REL + 4) @(negedge clock);
        chk1(irqOut_n, 1'b0);
        wr(ADDR_CONFIG, 8'h01);
        wr(ADDR_FLAGS, 8'h01);
        chk1(irqOut_n, 1'b0);
        host_model_inst.drain(1);
        wr(ADDR_FLAGS, 8'h01);
        chk1(irqOut_n, 1'b1);
        $display("release test done");
        summarize();
    end
    // Watchdog, well beyond the several hundred cycles the run needs
    initial
    begin
        repeat (20000) @(posedge clock);
        errorCnt++;
        summarize();
    end
endmodule
